// ==== rtl/sss_map.svh ====
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

// ****************************************************************
// Register byte offsets on the Wishbone bus.
// ****************************************************************
`define SSS_TXCTL_OFS 8'h00
`define SSS_RXCTL_OFS 8'h04
`define SSS_TXDAT_OFS 8'h08
`define SSS_RXDAT_OFS 8'h0C
`define SSS_IRQCTL_OFS 8'h10
`define SSS_PIE_OFS 8'h14
`define SSS_PIR_OFS 8'h18
`define SSS_BAUD_OFS 8'h1C
`define SSS_BRGL_OFS 8'h20
`define SSS_BRGH_OFS 8'h24

// ****************************************************************
// Field positions.
// ****************************************************************
`define SSS_TX_CLOCK_SOURCE_MASTER 7
`define SSS_TX_TX9 6
`define SSS_TX_TRANSMIT_ENABLE 5
`define SSS_TX_SYNC 4
`define SSS_TX_TRMT 1
`define SSS_TX_NINTH_TX_BIT 0
`define SSS_RX_PORT_ENABLE 7
`define SSS_RX_RX9 6
`define SSS_RX_SINGLE_RX_ENABLE 5
`define SSS_RX_CONTINUOUS_RX_ENABLE 4
`define SSS_RX_OVERRUN_FLAG 1
`define SSS_RX_NINTH_RX_BIT 0
`define SSS_IRQ_GIE 7
`define SSS_IRQ_PERIPH_IRQ_ENABLE 6
`define SSS_PI_RC 5
`define SSS_PI_TX 4
`define SSS_BAUD_IDLE 6

// ****************************************************************
// Reset values, masks and counts.
// ****************************************************************
`define SSS_REG_RST 8'h00
`define SSS_BAUD_WMASK 8'h9B
`define SSS_LAST8 4'h7
`define SSS_LAST9 4'h8
`define SSS_FIFO_DEPTH 2'h2

`endif

// ==== rtl/sss_pkg.sv ====
package sss_pkg;

   // Operating mode of the port, one-hot.
   typedef enum logic [2:0] {
      SSS_OFF = 3'b001,
      SSS_TX = 3'b010,
      SSS_RX = 3'b100
   } sss_mode_t;

   // One character with its optional ninth bit.
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } sss_char_t;

   // Synchroniser state.
   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] q;
   } sss_sync_st_t;

   // Receive queue state.
   typedef struct packed {
      sss_char_t [1:0] mem;
      logic rd;
      logic wr;
      logic [1:0] cnt;
   } sss_fifo_st_t;

   // Port state.
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      sss_mode_t mode;
      logic clock_source_master;
      logic tx9;
      logic transmit_enable;
      logic sync;
      logic ninth_tx_bit;
      logic port_enable;
      logic rx9;
      logic single_rx_enable;
      logic continuous_rx_enable;
      logic overrun_flag;
      logic global_irq_enable;
      logic periph_irq_enable;
      logic rx_irq_enable;
      logic tx_irq_enable;
      logic [7:0] baud;
      logic [7:0] brg_lo;
      logic [7:0] brg_hi;
      sss_char_t hold;
      logic hold_full;
      sss_char_t tx_shift_reg;
      logic tx_busy;
      logic [3:0] tx_cnt;
      logic [8:0] rx_shift_reg;
      logic [3:0] rx_cnt;
      logic ck_prev;
      logic dt_out;
      logic wake;
      logic vector;
   } sss_st_t;

endpackage : sss_pkg

// ==== rtl/sss_sync.sv ====
`timescale 1ns/1ps

module sss_sync (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin levels.
   input wire logic [1:0] d_i,
   output logic [1:0] q_o
);

   sss_pkg::sss_sync_st_t st;
   sss_pkg::sss_sync_st_t next_st;

   // Two stages; only the second stage is seen outside.
   always_comb begin
      next_st = st;
      next_st.meta = d_i;
      next_st.q = st.meta;
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.q;

endmodule : sss_sync

// ==== rtl/sss_rx_fifo.sv ====
`timescale 1ns/1ps
`include "sss_map.svh"

module sss_rx_fifo (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side.
   input wire logic push_i,
   input wire sss_pkg::sss_char_t char_i,
   input wire logic flush_i,
   // Drain side.
   input wire logic pop_i,
   output sss_pkg::sss_char_t head_o,
   output logic empty_o,
   output logic full_o
);

   sss_pkg::sss_fifo_st_t st;
   sss_pkg::sss_fifo_st_t next_st;
   logic push_ok;
   logic pop_ok;

   assign push_ok = push_i & (st.cnt != `SSS_FIFO_DEPTH);
   assign pop_ok = pop_i & (st.cnt != 2'h0);

   // Two-entry queue; a push into a full queue is dropped here.
   always_comb begin
      next_st = st;
      if (flush_i) begin
         next_st = '0;
      end else begin
         if (push_ok) begin
            next_st.mem[st.wr] = char_i;
            next_st.wr = ~st.wr;
         end
         if (pop_ok) begin
            next_st.rd = ~st.rd;
         end
         next_st.cnt = st.cnt + {1'b0, push_ok} - {1'b0, pop_ok};
      end
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign head_o = st.mem[st.rd];
   assign empty_o = (st.cnt == 2'h0);
   assign full_o = (st.cnt == `SSS_FIFO_DEPTH);

endmodule : sss_rx_fifo

// ==== rtl/sss_port.sv ====
// Summary of operation
// - Sync select bit enables synchronous operation.
// - Master bit clear: clock from pin.
// - Both receive enables clear means transmit.
// - Port enable gates and resets port.
// - First written character loads shifter at once.
// - Second character waits; transmit flag stays clear.
// - After shift-out, reload then set flag.
// - Transmit flag with enables wakes core.
// - Slave receiver is never idle; the idle bit here reads set while the bit count is zero.
// - Single receive enable ignored in slave; here it selects receive mode just as the continuous enable does.
// - Character received in sleep reaches data.
// - Receive interrupt wakes core, vector if global.
// - Receive flag set on character completion.
// - Clearing continuous enable or port clears overrun.
// - Clock driver off; data on leading edge.
// - Two-deep queue; third sets overrun, blocks.
// - Only synchronous slave runs during sleep.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "sss_map.svh"

module sss_port (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial clock pin.
   input wire logic ck_i,
   input wire logic ck_analog_i,
   output logic ck_o,
   output logic ck_oe_o,
   // Serial data pin.
   input wire logic dt_i,
   input wire logic dt_analog_i,
   output logic dt_o,
   output logic dt_oe_o,
   // Core wake.
   output logic wake_o,
   output logic vector_o
);

   // ****************************************************************
   // Signals
   // ****************************************************************
   sss_pkg::sss_st_t st;
   sss_pkg::sss_st_t next_st;
   logic [1:0] pin_raw;
   logic [1:0] pin_s;
   logic ck_s;
   logic dt_s;
   logic ck_rise;
   logic ck_fall;
   logic req;
   logic [3:0] last_tx;
   logic [3:0] last_rx;
   logic [8:0] tsr_bits;
   logic [8:0] rx_bits;
   logic push;
   logic pop;
   logic flush;
   sss_pkg::sss_char_t push_char;
   sss_pkg::sss_char_t head;
   logic fifo_empty;
   logic fifo_full;
   logic transmit_interrupt_flag;
   logic receive_interrupt_flag;

   // ****************************************************************
   // Pin capture
   // ****************************************************************
   // Raw pin levels go straight into the synchroniser, untouched by logic.
   assign pin_raw = {ck_i, dt_i};

   sss_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pin_raw),
      .q_o(pin_s)
   );

   // Both pins share one synchroniser; an analog-selected pin reads low.
   assign ck_s = pin_s[1] & ~ck_analog_i;
   assign dt_s = pin_s[0] & ~dt_analog_i;
   assign ck_rise = ck_s & ~st.ck_prev;
   assign ck_fall = ~ck_s & st.ck_prev;

   // ****************************************************************
   // Receive queue
   // ****************************************************************
   sss_rx_fifo u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(push),
      .char_i(push_char),
      .flush_i(flush),
      .pop_i(pop),
      .head_o(head),
      .empty_o(fifo_empty),
      .full_o(fifo_full)
   );

   // Derived terms for the engines and the bus.
   assign req = wb_cyc_i & wb_stb_i & ~st.ack;
   assign last_tx = st.tx9 ? `SSS_LAST9 : `SSS_LAST8;
   assign last_rx = st.rx9 ? `SSS_LAST9 : `SSS_LAST8;
   assign tsr_bits = {st.tx_shift_reg.ninth, st.tx_shift_reg.data};
   assign transmit_interrupt_flag = ~st.hold_full;
   assign receive_interrupt_flag = ~fifo_empty;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // One process drives the whole port; later sections override earlier.
   always_comb begin
      next_st = st;
      push = 1'b0;
      pop = 1'b0;
      flush = 1'b0;
      push_char = '0;
      rx_bits = st.rx_shift_reg;
      next_st.ck_prev = ck_s;
      next_st.ack = req;
      next_st.rdata = '0;

      // Only slave synchronous modes run at all, so sleep changes nothing.
      if (!st.port_enable || !st.sync || st.clock_source_master) begin
         next_st.mode = sss_pkg::SSS_OFF;
      end else if (st.single_rx_enable || st.continuous_rx_enable) begin
         next_st.mode = sss_pkg::SSS_RX;
      end else if (st.transmit_enable) begin
         next_st.mode = sss_pkg::SSS_TX;
      end else begin
         next_st.mode = sss_pkg::SSS_OFF;
      end

      // Transmit: load from holding, drive on rise, count on fall.
      if (st.mode == sss_pkg::SSS_TX) begin
         if (!st.tx_busy && st.hold_full) begin
            next_st.tx_shift_reg = st.hold;
            next_st.tx_busy = 1'b1;
            next_st.tx_cnt = '0;
            next_st.hold_full = 1'b0;
         end else if (st.tx_busy && ck_rise) begin
            next_st.dt_out = tsr_bits[st.tx_cnt];
         end else if (st.tx_busy && ck_fall) begin
            if (st.tx_cnt == last_tx) begin
               next_st.tx_busy = 1'b0;
               next_st.tx_cnt = '0;
            end else begin
               next_st.tx_cnt = st.tx_cnt + 4'h1;
            end
         end
      end

      // The overrun clears first so that a new overrun still sets it.
      if (!st.continuous_rx_enable) begin
         next_st.overrun_flag = 1'b0;
      end

      // Receive: sample on the trailing edge, stop while overrun stands.
      if (st.mode == sss_pkg::SSS_RX && !st.overrun_flag && ck_fall) begin
         rx_bits[st.rx_cnt] = dt_s;
         next_st.rx_shift_reg = rx_bits;
         if (st.rx_cnt == last_rx) begin
            next_st.rx_cnt = '0;
            if (fifo_full) begin
               next_st.overrun_flag = 1'b1;
            end else begin
               push = 1'b1;
               push_char.ninth = st.rx9 & rx_bits[8];
               push_char.data = rx_bits[7:0];
            end
         end else begin
            next_st.rx_cnt = st.rx_cnt + 4'h1;
         end
      end

      // Register writes; only the low byte lane carries data.
      if (req && wb_we_i && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            `SSS_TXCTL_OFS: begin
               next_st.clock_source_master = wb_dat_i[`SSS_TX_CLOCK_SOURCE_MASTER];
               next_st.tx9 = wb_dat_i[`SSS_TX_TX9];
               next_st.transmit_enable = wb_dat_i[`SSS_TX_TRANSMIT_ENABLE];
               next_st.sync = wb_dat_i[`SSS_TX_SYNC];
               next_st.ninth_tx_bit = wb_dat_i[`SSS_TX_NINTH_TX_BIT];
            end
            `SSS_RXCTL_OFS: begin
               next_st.port_enable = wb_dat_i[`SSS_RX_PORT_ENABLE];
               next_st.rx9 = wb_dat_i[`SSS_RX_RX9];
               next_st.single_rx_enable = wb_dat_i[`SSS_RX_SINGLE_RX_ENABLE];
               next_st.continuous_rx_enable = wb_dat_i[`SSS_RX_CONTINUOUS_RX_ENABLE];
            end
            `SSS_TXDAT_OFS: begin
               next_st.hold.ninth = st.ninth_tx_bit;
               next_st.hold.data = wb_dat_i[7:0];
               next_st.hold_full = 1'b1;
            end
            `SSS_IRQCTL_OFS: begin
               next_st.global_irq_enable = wb_dat_i[`SSS_IRQ_GIE];
               next_st.periph_irq_enable = wb_dat_i[`SSS_IRQ_PERIPH_IRQ_ENABLE];
            end
            `SSS_PIE_OFS: begin
               next_st.rx_irq_enable = wb_dat_i[`SSS_PI_RC];
               next_st.tx_irq_enable = wb_dat_i[`SSS_PI_TX];
            end
            `SSS_BAUD_OFS: next_st.baud = wb_dat_i[7:0] & `SSS_BAUD_WMASK;
            `SSS_BRGL_OFS: next_st.brg_lo = wb_dat_i[7:0];
            `SSS_BRGH_OFS: next_st.brg_hi = wb_dat_i[7:0];
            default: ;
         endcase
      end

      // Register reads; unmapped words read as zero.
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            `SSS_TXCTL_OFS: begin
               next_st.rdata[`SSS_TX_CLOCK_SOURCE_MASTER] = st.clock_source_master;
               next_st.rdata[`SSS_TX_TX9] = st.tx9;
               next_st.rdata[`SSS_TX_TRANSMIT_ENABLE] = st.transmit_enable;
               next_st.rdata[`SSS_TX_SYNC] = st.sync;
               next_st.rdata[`SSS_TX_TRMT] = ~st.tx_busy;
               next_st.rdata[`SSS_TX_NINTH_TX_BIT] = st.ninth_tx_bit;
            end
            `SSS_RXCTL_OFS: begin
               next_st.rdata[`SSS_RX_PORT_ENABLE] = st.port_enable;
               next_st.rdata[`SSS_RX_RX9] = st.rx9;
               next_st.rdata[`SSS_RX_SINGLE_RX_ENABLE] = st.single_rx_enable;
               next_st.rdata[`SSS_RX_CONTINUOUS_RX_ENABLE] = st.continuous_rx_enable;
               next_st.rdata[`SSS_RX_OVERRUN_FLAG] = st.overrun_flag;
               next_st.rdata[`SSS_RX_NINTH_RX_BIT] = head.ninth;
            end
            `SSS_RXDAT_OFS: begin
               next_st.rdata[7:0] = head.data;
               pop = receive_interrupt_flag;
            end
            `SSS_IRQCTL_OFS: begin
               next_st.rdata[`SSS_IRQ_GIE] = st.global_irq_enable;
               next_st.rdata[`SSS_IRQ_PERIPH_IRQ_ENABLE] = st.periph_irq_enable;
            end
            `SSS_PIE_OFS: begin
               next_st.rdata[`SSS_PI_RC] = st.rx_irq_enable;
               next_st.rdata[`SSS_PI_TX] = st.tx_irq_enable;
            end
            `SSS_PIR_OFS: begin
               next_st.rdata[`SSS_PI_RC] = receive_interrupt_flag;
               next_st.rdata[`SSS_PI_TX] = transmit_interrupt_flag;
            end
            `SSS_BAUD_OFS: begin
               next_st.rdata[7:0] = st.baud;
               next_st.rdata[`SSS_BAUD_IDLE] = (st.rx_cnt == 4'h0);
            end
            `SSS_BRGL_OFS: next_st.rdata[7:0] = st.brg_lo;
            `SSS_BRGH_OFS: next_st.rdata[7:0] = st.brg_hi;
            default: ;
         endcase
      end

      // A disabled port drops every character in flight.
      if (!st.port_enable) begin
         next_st.hold_full = 1'b0;
         next_st.tx_busy = 1'b0;
         next_st.tx_cnt = '0;
         next_st.rx_cnt = '0;
         next_st.overrun_flag = 1'b0;
         next_st.dt_out = 1'b0;
         flush = 1'b1;
         push = 1'b0;
      end

      // Wake and vector requests follow the flags and enables.
      next_st.wake = st.periph_irq_enable & ((transmit_interrupt_flag & st.tx_irq_enable) | (receive_interrupt_flag & st.rx_irq_enable));
      next_st.vector = next_st.wake & st.global_irq_enable;
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.mode <= sss_pkg::SSS_OFF;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // The clock driver never turns on; the master owns that wire.
   assign ck_o = 1'b0;
   assign ck_oe_o = 1'b1;
   assign dt_o = st.dt_out;
   assign dt_oe_o = (st.mode != sss_pkg::SSS_TX);
   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.rdata;
   assign wake_o = st.wake;
   assign vector_o = st.vector;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sync_mode_a: assert property (!st.sync |=> st.mode == sss_pkg::SSS_OFF)
      else $error("port runs without sync select");
   slave_only_a: assert property (st.clock_source_master |=> st.mode == sss_pkg::SSS_OFF)
      else $error("port runs with master clock source");
   tx_select_a: assert property ((st.port_enable && st.sync && !st.clock_source_master && !st.single_rx_enable
         && !st.continuous_rx_enable && st.transmit_enable) |=> st.mode == sss_pkg::SSS_TX)
      else $error("transmit mode not entered");
   rx_select_a: assert property ((st.port_enable && st.sync && !st.clock_source_master
         && (st.single_rx_enable || st.continuous_rx_enable)) |=> st.mode == sss_pkg::SSS_RX)
      else $error("receive mode not entered");
   port_reset_a: assert property (!st.port_enable |=> !st.tx_busy && !st.hold_full
         && fifo_empty && st.mode == sss_pkg::SSS_OFF)
      else $error("disabled port kept state");
   tx_load_a: assert property ((st.mode == sss_pkg::SSS_TX && st.port_enable
         && !st.tx_busy && st.hold_full) |=> st.tx_busy && st.tx_shift_reg == $past(st.hold))
      else $error("holding character not loaded");
   tx_wait_a: assert property ((st.mode == sss_pkg::SSS_TX && st.port_enable
         && st.tx_busy && st.hold_full && !ck_fall) |=> st.hold_full && !transmit_interrupt_flag)
      else $error("second character left holding early");
   tx_reload_a: assert property ((st.mode == sss_pkg::SSS_TX && st.port_enable
         && st.tx_busy && ck_fall && st.tx_cnt == last_tx && st.hold_full
         && st.transmit_enable && st.sync && !st.clock_source_master && !st.single_rx_enable && !st.continuous_rx_enable)
         |=> !st.tx_busy ##1 st.tx_busy)
      else $error("pending character not reloaded");
   tx_wake_a: assert property ((st.periph_irq_enable && st.tx_irq_enable && transmit_interrupt_flag) |=> wake_o)
      else $error("transmit flag did not wake");
   rx_done_a: assert property ((st.mode == sss_pkg::SSS_RX && st.port_enable
         && !st.overrun_flag && ck_fall && st.rx_cnt == last_rx && !fifo_full)
         |=> receive_interrupt_flag)
      else $error("completed character not queued");
   rx_vector_a: assert property ((receive_interrupt_flag && st.rx_irq_enable && st.periph_irq_enable && st.global_irq_enable)
         |=> wake_o && vector_o)
      else $error("receive interrupt not raised");
   overrun_set_a: assert property ((st.mode == sss_pkg::SSS_RX && st.port_enable
         && st.continuous_rx_enable && !st.overrun_flag && ck_fall && st.rx_cnt == last_rx && fifo_full)
         |=> st.overrun_flag && fifo_full)
      else $error("third character not flagged");
   overrun_clr_a: assert property ((!st.continuous_rx_enable || !st.port_enable)
         && !(ck_fall && st.rx_cnt == last_rx) |=> !st.overrun_flag)
      else $error("overrun not cleared");
   data_edge_a: assert property ((st.mode == sss_pkg::SSS_TX && st.port_enable
         && !ck_rise) |=> $stable(dt_o))
      else $error("data changed off the leading edge");
   lsb_first_a: assert property ((st.mode == sss_pkg::SSS_TX && st.port_enable
         && st.tx_busy && ck_rise && st.tx_cnt == 4'h0) |=> dt_o == $past(st.tx_shift_reg.data[0]))
      else $error("first bit is not the least significant");

   tx_done_c: cover property (st.tx_busy && ck_fall && st.tx_cnt == last_tx);
   rx_push_c: cover property (push);
   overrun_c: cover property (!st.overrun_flag ##1 st.overrun_flag);
endmodule : sss_port

// ==== test/sss_master.sv ====
`timescale 1ns/1ps

// ****************************************************************
// External synchronous master: drives the bit clock and data line.
// ****************************************************************
module sss_master (
   // Link pins.
   output logic ck_o,
   output logic dt_o,
   input wire logic dt_i
);
   // The clock stands low between frames.
   initial begin
      ck_o = 1'b0;
      dt_o = 1'b0;
   end

   // One frame: one clock per bit, exactly nbits clocks.
   task automatic frame(input int nbits, input logic [8:0] tx, output logic [8:0] rx);
      rx = 9'h000;
      // Pin edges sit off the system clock edge so the slave never sees a race.
      #30;
      for (int k = 0; k < nbits; k++) begin
         ck_o = 1'b1;
         dt_o = tx[k]; // Data changes on the leading edge, lowest bit first.
         #400;
         // The slave's bit must already be valid at the trailing edge.
         rx[k] = dt_i;
         ck_o = 1'b0;
         #400;
      end
      dt_o = ~dt_o; // Released line: never leave the last bit standing.
   endtask : frame
endmodule : sss_master

// ==== test/sss_port_tb.sv ====
`timescale 1ns/1ps
`include "sss_map.svh"

module sss_port_tb;
   logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, ck, m_dt, dt_line, ck_oe, dt_oe, dt_o;
   logic wb_ack, wake, vector, ana, ck_drv;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   logic [8:0] q, r;
   logic [8:0] c [3];
   logic [7:0] v;
   int num_errors, cmp_count, seed, cycles;
   localparam logic [7:0] RST_TAB [7] = '{`SSS_RXCTL_OFS, `SSS_IRQCTL_OFS, `SSS_PIE_OFS,
      `SSS_BRGL_OFS, `SSS_BRGH_OFS, `SSS_TXDAT_OFS, 8'h28};
   localparam logic [7:0] RW_TAB [5] = '{`SSS_IRQCTL_OFS, `SSS_PIE_OFS, `SSS_BRGL_OFS,
      `SSS_BRGH_OFS, `SSS_BAUD_OFS};
   localparam logic [7:0] MASK_TAB [5] = '{8'hC0, 8'h30, 8'hFF, 8'hFF, 8'h9B};

   // The device drives the data line only while its enable is low.
   assign dt_line = dt_oe ? m_dt : dt_o;

   sss_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .ck_i(ck), .ck_analog_i(ana), .ck_o(ck_drv),
      .ck_oe_o(ck_oe), .dt_i(dt_line), .dt_analog_i(ana), .dt_o(dt_o), .dt_oe_o(dt_oe),
      .wake_o(wake), .vector_o(vector));

   sss_master i_master (.ck_o(ck), .dt_o(m_dt), .dt_i(dt_line));

   // ****************************************************************
   // Clock, watchdog and helpers.
   // ****************************************************************
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // A hang is cut short well beyond the thousand or so cycles the run needs.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Expected control byte: overrun flag above the ninth bit.
   function automatic logic [8:0] ctl_exp(input logic overrun_flag, input logic ninth);
      return {7'h00, overrun_flag, ninth};
   endfunction : ctl_exp

   // One classic Wishbone cycle; held until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                     input logic [3:0] sel);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_dat <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      q = {1'b0, wb_dat_o[7:0]};
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      wb(1'b1, adr, d, 4'hF);
   endtask : wr

   task automatic rd(input logic [7:0] adr);
      wb(1'b0, adr, 8'h00, 4'hF);
   endtask : rd

   // Three whole 9-bit characters from the master.
   task automatic rx3();
      for (int k = 0; k < 3; k++) begin
         c[k] = 9'($random(seed));
         i_master.frame(9, c[k], r);
         @(posedge clk_i);
      end
   endtask : rx3

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      rst_i = 1'b1;
      {wb_cyc, wb_stb, wb_we, ana} = 4'b0000;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_dat = 32'h0000_0000;
      num_errors = 0;
      cmp_count = 0;
      cycles = 0;
      seed = 98134;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset values, write-only and unmapped places read zero.
      foreach (RST_TAB[k]) begin
         rd(RST_TAB[k]);
         check(q, 9'h000);
      end
      // Random write and read back through the writable masks.
      foreach (RW_TAB[k]) begin
         v = 8'($random(seed));
         wr(RW_TAB[k], v);
         rd(RW_TAB[k]);
         check(q & {1'b0, MASK_TAB[k]}, {1'b0, v & MASK_TAB[k]});
      end
      // A write without the low byte lane is dropped.
      wr(`SSS_BRGH_OFS, v);
      wb(1'b1, `SSS_BRGH_OFS, ~v, 4'hE);
      wr(8'h28, 8'hFF);
      rd(`SSS_BRGH_OFS);
      check(q, {1'b0, v});
      // Slave transmit: two characters queued, ninth bit set before each write.
      c[0] = 9'($random(seed));
      c[1] = 9'($random(seed));
      wr(`SSS_RXCTL_OFS, 8'h80);
      wr(`SSS_TXCTL_OFS, 8'h50);
      wr(`SSS_IRQCTL_OFS, 8'hC0);
      wr(`SSS_PIE_OFS, 8'h10);
      wr(`SSS_TXCTL_OFS, {7'h38, c[0][8]});
      check({7'h00, ck_oe, ck_drv}, 9'h002);
      check({8'h00, dt_oe}, 9'h000);
      wr(`SSS_TXDAT_OFS, c[0][7:0]);
      wr(`SSS_TXCTL_OFS, {7'h38, c[1][8]});
      wr(`SSS_TXDAT_OFS, c[1][7:0]);
      rd(`SSS_PIR_OFS);
      check(q & 9'h030, 9'h000);
      check({7'h00, wake, vector}, 9'h000);
      i_master.frame(9, 9'h000, r);
      @(posedge clk_i);
      check(r, c[0]);
      rd(`SSS_PIR_OFS);
      check(q & 9'h030, 9'h010);
      check({7'h00, wake, vector}, 9'h003);
      i_master.frame(9, 9'h000, r);
      @(posedge clk_i);
      check(r, c[1]);
      // Slave receive with both enables set: never single-shot, fills to overrun.
      wr(`SSS_TXCTL_OFS, 8'h10);
      wr(`SSS_PIE_OFS, 8'h20);
      wr(`SSS_RXCTL_OFS, 8'hF0);
      check({8'h00, dt_oe}, 9'h001);
      rx3();
      rd(`SSS_PIR_OFS);
      check(q & 9'h020, 9'h020);
      check({7'h00, wake, vector}, 9'h003);
      for (int k = 0; k < 2; k++) begin
         rd(`SSS_RXCTL_OFS);
         check(q & 9'h003, ctl_exp(1'b1, c[k][8]));
         rd(`SSS_RXDAT_OFS);
         check(q, {1'b0, c[k][7:0]});
      end
      rd(`SSS_PIR_OFS);
      check(q & 9'h020, 9'h000);
      // While overrun stands nothing more is taken in.
      i_master.frame(9, 9'h155, r);
      @(posedge clk_i);
      rd(`SSS_PIR_OFS);
      check(q & 9'h020, 9'h000);
      wr(`SSS_RXCTL_OFS, 8'hC0);
      rd(`SSS_RXCTL_OFS);
      check(q & 9'h002, 9'h000);
      // Overrun again, then disabling the port clears flag and queue.
      wr(`SSS_RXCTL_OFS, 8'hD0);
      rx3();
      rd(`SSS_RXCTL_OFS);
      check(q & 9'h002, 9'h002);
      wr(`SSS_RXCTL_OFS, 8'h50);
      rd(`SSS_RXCTL_OFS);
      check(q & 9'h002, 9'h000);
      rd(`SSS_PIR_OFS);
      check(q & 9'h020, 9'h000);
      // With the pins left analog-selected the receiver hears no clock.
      wr(`SSS_RXCTL_OFS, 8'hD0);
      ana <= 1'b1;
      i_master.frame(9, 9'h1FF, r);
      @(posedge clk_i);
      ana <= 1'b0;
      rd(`SSS_PIR_OFS);
      check(q & 9'h020, 9'h000);
      complete_run();
   end
endmodule : sss_port_tb
